/* File: logic/fpc_pkg.sv */
// package: flash program controller constants and types
package fpc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, 32-bit aligned words)
  // ----------------------------------------------------------------
  localparam logic [7:0] FPC_FLASH_CONTROL_OFS = 8'h00;
  localparam logic [7:0] FPC_AUX_CONTROL_OFS = 8'h04;
  localparam logic [7:0] FPC_EEPROM_CONTROL_OFS = 8'h08;
  localparam logic [7:0] FPC_ACCESS_ADDR_OFS = 8'h0C;
  localparam logic [7:0] FPC_ACCESS_DATA_OFS = 8'h10;
  localparam logic [7:0] FPC_ACCESS_CMD_OFS = 8'h14;
  localparam logic [7:0] FPC_STATUS_OFS = 8'h18;
  localparam logic [7:0] FPC_EXEC_CONTEXT_OFS = 8'h1C;
  // ----------------------------------------------------------------
  // flash, aux and eeprom control fields
  // ----------------------------------------------------------------
  localparam int FPC_KEY_MSB = 7;
  localparam int FPC_KEY_LSB = 4;
  localparam int FPC_LATCH_MAP_BIT = 3;
  localparam int FPC_SPACE_MSB = 2;
  localparam int FPC_SPACE_LSB = 1;
  localparam int FPC_BUSY_BIT = 0;
  localparam int FPC_BOOT_MAP_BIT = 0;
  localparam int FPC_EEPROM_MAP_BIT = 1;
  localparam logic [7:0] FPC_FLASH_CONTROL_RST = 8'h00;
  localparam logic [3:0] FPC_KEY_FIRST = 4'h5;
  localparam logic [3:0] FPC_KEY_SECOND = 4'hA;
  localparam logic [3:0] FPC_SECURITY_INIT = 4'h0;
  // ----------------------------------------------------------------
  // sizes and windows
  // ----------------------------------------------------------------
  localparam int FPC_PAGE_BYTES = 128;
  localparam int FPC_PAGES = 128;
  localparam int FPC_BOOT_BYTES = 2048;
  localparam logic [15:0] FPC_USER_TOP = 16'h3FFF;
  localparam logic [15:0] FPC_EXTRA_ROW_BASE = 16'hFF80;
  localparam logic [15:0] FPC_BOOT_BASE = 16'hF800;
  // ----------------------------------------------------------------
  // timing: erase and program times per byte slot
  // ----------------------------------------------------------------
  localparam int FPC_CLK_MHZ = 100;
  localparam int FPC_ERASE_NS = 100;
  localparam int FPC_PROG_NS = 100;
  localparam int FPC_ERASE_CYC = (FPC_ERASE_NS * FPC_CLK_MHZ + 999) / 1000;
  localparam int FPC_PROG_CYC = (FPC_PROG_NS * FPC_CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPC_SPACE_USER = 2'h0,
    FPC_SPACE_EXTRA_ROW = 2'h1,
    FPC_SPACE_SECURITY = 2'h2,
    FPC_SPACE_RESERVED = 2'h3
  } fpc_space_t;
  typedef enum logic [1:0] {
    FPC_CMD_CODE_READ = 2'h0,
    FPC_CMD_DATA_WRITE = 2'h1,
    FPC_CMD_INSTR = 2'h2
  } fpc_cmd_t;
  typedef enum logic [3:0] {
    FPC_ST_IDLE = 4'b0001,
    FPC_ST_ERASE = 4'b0010,
    FPC_ST_PROG = 4'b0100,
    FPC_ST_DONE = 4'b1000
  } fpc_state_t;
endpackage

/* File: logic/fpc_mem.sv */
// file: byte memory with registered read port
`timescale 1ns/1ns
module fpc_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("fpc_mem depth exceeds address range");
    end
  end
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge aclk) begin
    rdata <= mem[raddr];
  end
endmodule

/* File: logic/fpc_latch.sv */
// file: column latch buffer with per-byte loaded flags
`timescale 1ns/1ns
module fpc_latch #(
  parameter int BYTES = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [6:0] load_idx,
  input wire logic [7:0] load_data,
  input wire logic clear,
  input wire logic [6:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [BYTES-1:0] loaded
);
  logic [7:0] data [BYTES];
  initial begin
    if (BYTES != 128) begin
      $error("fpc_latch supports 128 bytes only");
    end
  end
  // per-byte loaded flags; a load in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < BYTES; g++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          loaded[g] <= 1'b0;
        end else if (load && load_idx == 7'(g)) begin
          loaded[g] <= 1'b1;
        end else if (clear) begin
          loaded[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (load) begin
      data[load_idx] <= load_data;
    end
  end
  always_ff @(posedge aclk) begin
    rd_data <= data[rd_idx];
  end
endmodule

/* File: logic/fpc_top.sv */
// file: flash program controller top with axi4-lite register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module fpc_top
  import fpc_pkg::*;
#(
  parameter int PAGE_BYTES = FPC_PAGE_BYTES,
  parameter int PAGES = FPC_PAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic program_busy_flag,
  output logic boot_map_enable
);
  initial begin
    if (PAGE_BYTES != 128 || PAGES != 128) begin
      $error("fpc_top supports 128 pages of 128 bytes only");
    end
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] launch_key_nibble;
  logic latch_map_select;
  logic [1:0] space_select;
  logic key_armed;
  logic eeprom_map_enable;
  logic exec_from_boot;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic acc_denied;
  logic [3:0] security_high;
  logic [3:0] security_low;
  logic [6:0] target_page;
  fpc_state_t state;
  logic [6:0] byte_idx;
  logic [7:0] wait_cnt;
  logic read_pending;
  logic [1:0] read_src;
  // bus handshake state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // ----------------------------------------------------------------
  // write channel capture, either order
  // ----------------------------------------------------------------
  logic wr_fire;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end
  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_ok;
  logic wr_ctrl;
  logic wr_aux;
  logic wr_eeprom_control_reg;
  logic wr_addr;
  logic wr_data;
  logic wr_cmd;
  logic wr_ctx;
  logic lane0;
  always_comb begin
    wr_ok = 1'b1;
    wr_ctrl = 1'b0;
    wr_aux = 1'b0;
    wr_eeprom_control_reg = 1'b0;
    wr_addr = 1'b0;
    wr_data = 1'b0;
    wr_cmd = 1'b0;
    wr_ctx = 1'b0;
    if (aw_addr == FPC_FLASH_CONTROL_OFS) begin
      wr_ctrl = wr_fire;
    end else if (aw_addr == FPC_AUX_CONTROL_OFS) begin
      wr_aux = wr_fire;
    end else if (aw_addr == FPC_EEPROM_CONTROL_OFS) begin
      wr_eeprom_control_reg = wr_fire;
    end else if (aw_addr == FPC_ACCESS_ADDR_OFS) begin
      wr_addr = wr_fire;
    end else if (aw_addr == FPC_ACCESS_DATA_OFS) begin
      wr_data = wr_fire;
    end else if (aw_addr == FPC_ACCESS_CMD_OFS) begin
      wr_cmd = wr_fire;
    end else if (aw_addr == FPC_EXEC_CONTEXT_OFS) begin
      wr_ctx = wr_fire;
    end else if (aw_addr != FPC_STATUS_OFS) begin
      wr_ok = 1'b0;
    end
  end
  assign lane0 = w_strb[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // cpu access emulation: code read, data write, other instruction
  // ----------------------------------------------------------------
  logic cmd_code_read;
  logic cmd_data_write;
  logic cmd_instr;
  assign cmd_code_read = wr_cmd && lane0 && w_data[1:0] == FPC_CMD_CODE_READ;
  assign cmd_data_write = wr_cmd && lane0 && w_data[1:0] == FPC_CMD_DATA_WRITE;
  assign cmd_instr = wr_cmd && lane0 && w_data[1:0] == FPC_CMD_INSTR;
  logic latch_load;
  assign latch_load = cmd_data_write && latch_map_select && acc_addr <= FPC_USER_TOP
    && state == FPC_ST_IDLE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_addr <= 16'h0000;
      acc_wdata <= 8'h00;
    end else begin
      if (wr_addr && lane0) begin
        acc_addr[7:0] <= w_data[7:0];
      end
      if (wr_addr && w_strb[1]) begin
        acc_addr[15:8] <= w_data[15:8];
      end
      if (wr_data && lane0) begin
        acc_wdata <= w_data[7:0];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_from_boot <= 1'b0;
    end else if (wr_ctx && lane0) begin
      exec_from_boot <= w_data[0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_map_enable <= 1'b0;
    end else if (wr_aux && lane0) begin
      boot_map_enable <= w_data[FPC_BOOT_MAP_BIT];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eeprom_map_enable <= 1'b0;
    end else if (wr_eeprom_control_reg && lane0) begin
      eeprom_map_enable <= w_data[FPC_EEPROM_MAP_BIT];
    end
  end
  // ----------------------------------------------------------------
  // flash control register and launch key
  // ----------------------------------------------------------------
  logic launch;
  logic key_write;
  assign key_write = wr_ctrl && lane0;
  // key A after armed 5, boot context, non-reserved space
  assign launch = key_write && key_armed && w_data[FPC_KEY_MSB:FPC_KEY_LSB] == FPC_KEY_SECOND
    && exec_from_boot && w_data[FPC_SPACE_MSB:FPC_SPACE_LSB] != FPC_SPACE_RESERVED
    && state == FPC_ST_IDLE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      launch_key_nibble <= FPC_FLASH_CONTROL_RST[FPC_KEY_MSB:FPC_KEY_LSB];
      latch_map_select <= FPC_FLASH_CONTROL_RST[FPC_LATCH_MAP_BIT];
      space_select <= FPC_FLASH_CONTROL_RST[FPC_SPACE_MSB:FPC_SPACE_LSB];
    end else if (key_write) begin
      launch_key_nibble <= w_data[FPC_KEY_MSB:FPC_KEY_LSB];
      latch_map_select <= w_data[FPC_LATCH_MAP_BIT];
      space_select <= w_data[FPC_SPACE_MSB:FPC_SPACE_LSB];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_armed <= 1'b0;
    end else if (key_write) begin
      key_armed <= w_data[FPC_KEY_MSB:FPC_KEY_LSB] == FPC_KEY_FIRST;
    end else if (wr_fire || cmd_instr) begin
      key_armed <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_page <= 7'h00;
    end else if (latch_load) begin
      target_page <= acc_addr[13:7];
    end
  end
  // ----------------------------------------------------------------
  // erase-then-program sequencer
  // ----------------------------------------------------------------
  logic [PAGE_BYTES-1:0] loaded;
  logic [7:0] latch_rd;
  logic [1:0] prog_space;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_space <= 2'h0;
    end else if (launch) begin
      prog_space <= w_data[FPC_SPACE_MSB:FPC_SPACE_LSB];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= FPC_ST_IDLE;
      byte_idx <= 7'h00;
      wait_cnt <= 8'h00;
    end else begin
      case (state)
        FPC_ST_IDLE: begin
          if (launch) begin
            state <= FPC_ST_ERASE;
            byte_idx <= 7'h00;
            wait_cnt <= 8'(FPC_ERASE_CYC);
          end
        end
        FPC_ST_ERASE: begin
          if (wait_cnt > 8'h01) begin
            wait_cnt <= wait_cnt - 8'h01;
          end else begin
            state <= FPC_ST_PROG;
            wait_cnt <= 8'(FPC_PROG_CYC);
          end
        end
        FPC_ST_PROG: begin
          if (wait_cnt > 8'h01) begin
            wait_cnt <= wait_cnt - 8'h01;
          end else if (byte_idx == 7'h7F) begin
            state <= FPC_ST_DONE;
          end else begin
            state <= FPC_ST_ERASE;
            byte_idx <= byte_idx + 7'h01;
            wait_cnt <= 8'(FPC_ERASE_CYC);
          end
        end
        default: begin
          state <= FPC_ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_busy_flag <= 1'b0;
    end else begin
      program_busy_flag <= launch || (state != FPC_ST_IDLE && state != FPC_ST_DONE);
    end
  end
  // commit strobe: latch data registered at byte_idx, valid in PROG
  logic commit;
  logic commit_user;
  logic commit_extra_row;
  assign commit = state == FPC_ST_PROG && wait_cnt == 8'h01 && loaded[byte_idx];
  assign commit_user = commit && prog_space == FPC_SPACE_USER;
  assign commit_extra_row = commit && prog_space == FPC_SPACE_EXTRA_ROW;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      security_high <= FPC_SECURITY_INIT;
      security_low <= FPC_SECURITY_INIT;
    end else if (commit && prog_space == FPC_SPACE_SECURITY && byte_idx == 7'h00) begin
      security_high <= latch_rd[7:4];
    end
  end
  fpc_latch #(
    .BYTES(PAGE_BYTES)
  ) u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(latch_load),
    .load_idx(acc_addr[6:0]),
    .load_data(acc_wdata),
    .clear(state == FPC_ST_DONE),
    .rd_idx(byte_idx),
    .rd_data(latch_rd),
    .loaded(loaded)
  );
  // ----------------------------------------------------------------
  // arrays: user, extra row, boot
  // ----------------------------------------------------------------
  logic [7:0] user_rd;
  logic [7:0] extra_row_rd;
  logic [7:0] boot_rd;
  fpc_mem #(
    .DEPTH(PAGES * PAGE_BYTES),
    .AW(14)
  ) u_user_flash_array (
    .aclk(aclk),
    .we(commit_user),
    .waddr({target_page, byte_idx}),
    .wdata(latch_rd),
    .raddr(acc_addr[13:0]),
    .rdata(user_rd)
  );
  fpc_mem #(
    .DEPTH(PAGE_BYTES),
    .AW(7)
  ) u_extra_row (
    .aclk(aclk),
    .we(commit_extra_row),
    .waddr(byte_idx),
    .wdata(latch_rd),
    .raddr(acc_addr[6:0]),
    .rdata(extra_row_rd)
  );
  fpc_mem #(
    .DEPTH(FPC_BOOT_BYTES),
    .AW(11)
  ) u_boot_flash_array (
    .aclk(aclk),
    .we(1'b0),
    .waddr(11'h000),
    .wdata(8'h00),
    .raddr(acc_addr[10:0]),
    .rdata(boot_rd)
  );
  // ----------------------------------------------------------------
  // code read routing
  // ----------------------------------------------------------------
  logic boot_hit;
  logic read_ok;
  logic [1:0] next_read_src;
  always_comb begin
    boot_hit = boot_map_enable && acc_addr >= FPC_BOOT_BASE;
    read_ok = 1'b1;
    next_read_src = 2'h0;
    if (boot_hit) begin
      next_read_src = 2'h3;
      read_ok = exec_from_boot;
    end else if (space_select == FPC_SPACE_EXTRA_ROW) begin
      next_read_src = 2'h1;
      read_ok = acc_addr >= FPC_EXTRA_ROW_BASE;
    end else if (space_select == FPC_SPACE_SECURITY) begin
      next_read_src = 2'h2;
      read_ok = acc_addr == 16'h0000;
    end else if (space_select == FPC_SPACE_USER) begin
      read_ok = acc_addr <= FPC_USER_TOP;
    end else begin
      read_ok = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_pending <= 1'b0;
      read_src <= 2'h0;
      acc_denied <= 1'b0;
      acc_rdata <= 8'h00;
    end else begin
      read_pending <= cmd_code_read && read_ok;
      if (cmd_code_read) begin
        read_src <= next_read_src;
        acc_denied <= !read_ok;
      end else if (cmd_data_write) begin
        acc_denied <= !latch_load;
      end
      if (read_pending) begin
        case (read_src)
          2'h1: acc_rdata <= extra_row_rd;
          2'h2: acc_rdata <= {security_high, security_low};
          2'h3: acc_rdata <= boot_rd;
          default: acc_rdata <= user_rd;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic rd_ok;
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == FPC_FLASH_CONTROL_OFS) begin
      next_rdata[7:0] = {launch_key_nibble, latch_map_select, space_select, program_busy_flag};
    end else if (s_axi_araddr == FPC_AUX_CONTROL_OFS) begin
      next_rdata[FPC_BOOT_MAP_BIT] = boot_map_enable;
    end else if (s_axi_araddr == FPC_EEPROM_CONTROL_OFS) begin
      next_rdata[FPC_EEPROM_MAP_BIT] = eeprom_map_enable;
    end else if (s_axi_araddr == FPC_ACCESS_ADDR_OFS) begin
      next_rdata[15:0] = acc_addr;
    end else if (s_axi_araddr == FPC_ACCESS_DATA_OFS) begin
      next_rdata[7:0] = acc_rdata;
    end else if (s_axi_araddr == FPC_STATUS_OFS) begin
      next_rdata[2:0] = {acc_denied, key_armed, program_busy_flag};
    end else if (s_axi_araddr == FPC_EXEC_CONTEXT_OFS) begin
      next_rdata[0] = exec_from_boot;
    end else if (s_axi_araddr != FPC_ACCESS_CMD_OFS) begin
      rd_ok = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: test/fpc_checker.sv */
// concurrent checks on the flash program controller ports
`timescale 1ns/1ns
module fpc_checker
  import fpc_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic program_busy_flag,
  input logic boot_map_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] since_a;
  always_ff @(posedge aclk) begin
    if (!aresetn) since_a <= 4'hF;
    else if (s_axi_wvalid && s_axi_wready && s_axi_wdata[7:4] == 4'hA) since_a <= 4'h0;
    else if (since_a != 4'hF) since_a <= since_a + 4'h1;
  end
  // longest busy run: every slot erased and programmed, plus the launch cycle
  localparam int BUSY_MAX = FPC_PAGE_BYTES * (FPC_ERASE_CYC + FPC_PROG_CYC) + 1;
  logic [11:0] busy_len;
  always_ff @(posedge aclk) begin
    if (!aresetn || !program_busy_flag) begin
      busy_len <= 12'h000;
    end else if (busy_len != 12'hFFF) begin
      busy_len <= busy_len + 12'h001;
    end
  end
  sequence s_busy_start;
    $rose(program_busy_flag);
  endsequence
  chk_key_before_busy: assert property (s_busy_start |-> since_a <= 4'h4)
    else $error("busy rose without a second key write");
  chk_busy_holds: assert property (s_busy_start |-> program_busy_flag [*8])
    else $error("busy dropped too early");
  chk_busy_ends: assert property (busy_len <= 12'(BUSY_MAX))
    else $error("busy never cleared");
  chk_reset_zero: assert property ($rose(aresetn) |-> !program_busy_flag && !boot_map_enable)
    else $error("outputs not zero after reset");
  chk_boot_quiet: assert property ($changed(boot_map_enable) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("boot map changed without a write");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  chk_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind fpc_top fpc_checker i_chk (.*);

/* File: test/fpc_cpu.sv */
// cpu side model issuing register accesses one at a time
`timescale 1ns/1ns
module fpc_cpu (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic s_axi_bready,
  input wire logic s_axi_bvalid,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic s_axi_rready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // no interrupts: accesses never interleave during programming
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tb.give_verdict(1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) tb.give_verdict(1'b1);
  endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the flash program controller
`timescale 1ns/1ns
module tb;
  import fpc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, program_busy_flag, boot_map_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int err_total, comparisons, n;
  fpc_top i_dut (.*);
  fpc_cpu i_cpu (.*);
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic ctrl(input logic [3:0] k, input logic m, input logic [1:0] sp);
    i_cpu.wr(FPC_FLASH_CONTROL_OFS, {24'h0, k, m, sp, 1'b0});
  endtask
  task automatic acc(input logic [15:0] a, input logic [1:0] c, input logic [7:0] v);
    i_cpu.wr(FPC_ACCESS_ADDR_OFS, {16'h0, a});
    i_cpu.wr(FPC_ACCESS_DATA_OFS, {24'h0, v});
    i_cpu.wr(FPC_ACCESS_CMD_OFS, {30'h0, c});
  endtask
  task automatic load(input logic [15:0] a, input logic [7:0] v);
    ctrl(4'h0, 1'b1, 2'h0);
    acc(a, FPC_CMD_DATA_WRITE, v);
    ctrl(4'h0, 1'b0, 2'h0);
  endtask
  task automatic launch(input logic [1:0] sp, input logic e);
    ctrl(FPC_KEY_FIRST, 1'b0, sp);
    ctrl(FPC_KEY_SECOND, 1'b0, sp);
    @(posedge aclk);
    chk("busy", {31'h0, e}, {31'h0, program_busy_flag});
    for (n = 0; n < 4000 && program_busy_flag !== 1'b0; n++) @(posedge aclk);
    if (n == 4000) give_verdict(1'b1);
  endtask
  task automatic cread(input logic [1:0] sp, input logic [15:0] a, input logic [7:0] e);
    ctrl(4'h0, 1'b0, sp);
    acc(a, FPC_CMD_CODE_READ, 8'h00);
    i_cpu.rd(FPC_ACCESS_DATA_OFS, d, r);
    chk("code byte", {24'h0, e}, d);
  endtask
  task automatic give_verdict(input bit tmo);
    if (tmo) err_total++;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    i_cpu.rd(FPC_FLASH_CONTROL_OFS, d, r);
    chk("control reset", 32'h0, d);
    i_cpu.rd(8'h40, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    i_cpu.wr(8'h40, 32'h0);
    chk("unmapped bresp", 32'h2, {30'h0, s_axi_bresp});
    ctrl(4'h0, 1'b0, 2'h0);
    i_cpu.wr(FPC_FLASH_CONTROL_OFS, 32'h1);
    i_cpu.rd(FPC_FLASH_CONTROL_OFS, d, r);
    chk("busy write", 32'h0, {31'h0, d[0]});
    $display("done: reset");
    i_cpu.wr(FPC_EXEC_CONTEXT_OFS, 32'h1);
    load(16'h0105, 8'h3C);
    load(16'h0087, 8'hC3);
    launch(FPC_SPACE_USER, 1'b1);
    cread(FPC_SPACE_USER, 16'h0085, 8'h3C);
    cread(FPC_SPACE_USER, 16'h0087, 8'hC3);
    i_cpu.wr(FPC_EEPROM_CONTROL_OFS, 32'h2);
    load(16'h0086, 8'h5A);
    launch(FPC_SPACE_USER, 1'b1);
    cread(FPC_SPACE_USER, 16'h0086, 8'h5A);
    cread(FPC_SPACE_USER, 16'h0085, 8'h3C);
    $display("done: user page");
    load(16'h0001, 8'h77);
    launch(FPC_SPACE_EXTRA_ROW, 1'b1);
    cread(FPC_SPACE_EXTRA_ROW, 16'hFF81, 8'h77);
    load(16'h0000, 8'hB7);
    launch(FPC_SPACE_SECURITY, 1'b1);
    cread(FPC_SPACE_SECURITY, 16'h0000, {4'hB, FPC_SECURITY_INIT});
    launch(FPC_SPACE_RESERVED, 1'b0);
    $display("done: spaces");
    ctrl(FPC_KEY_FIRST, 1'b0, 2'h0);
    i_cpu.wr(FPC_AUX_CONTROL_OFS, 32'h0);
    ctrl(FPC_KEY_SECOND, 1'b0, 2'h0);
    i_cpu.rd(FPC_STATUS_OFS, d, r);
    chk("aborted key", 32'h0, {31'h0, d[0]});
    i_cpu.wr(FPC_EXEC_CONTEXT_OFS, 32'h0);
    launch(FPC_SPACE_USER, 1'b0);
    i_cpu.wr(FPC_AUX_CONTROL_OFS, 32'h1);
    chk("boot map", 32'h1, {31'h0, boot_map_enable});
    acc(16'hF900, FPC_CMD_CODE_READ, 8'h00);
    i_cpu.rd(FPC_STATUS_OFS, d, r);
    chk("boot denied", 32'h1, {31'h0, d[2]});
    $display("done: protection");
    give_verdict(1'b0);
  end
endmodule
